// *** an_status_pkg.sv ***
// package: offsets, field positions, encodings and carrier structs of the negotiation status summary
package an_status_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h32;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 8'h40;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 8'h41;
    localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;

    // field positions in the summary word
    localparam int BIT_AN_DONE = 15;
    localparam int BIT_GOOD_CHECK = 14;
    localparam int BIT_ACK_DETECT = 13;
    localparam int BIT_ABIL_DETECT = 12;
    localparam int BIT_NP_WAIT = 11;
    localparam int SPEED_HI = 10;
    localparam int SPEED_LO = 8;
    localparam int BIT_PD_FAULT = 7;
    localparam int BIT_REM_FAULT = 6;
    localparam int BIT_PAGE_RX = 5;
    localparam int BIT_LP_AN_ABLE = 4;
    localparam int BIT_LP_NP_ABLE = 3;
    localparam int BIT_LINK_UP = 2;
    localparam int BIT_PAUSE_RX = 1;
    localparam int BIT_PAUSE_TX = 0;

    // sticky event bits in the interrupt status/mask words
    localparam int NUM_EVENTS = 6;
    localparam int EV_GOOD_CHECK = 0;
    localparam int EV_ACK_DETECT = 1;
    localparam int EV_ABIL_DETECT = 2;
    localparam int EV_NP_WAIT = 3;
    localparam int EV_PD_FAULT = 4;
    localparam int EV_PAGE_RX = 5;
    localparam logic [NUM_EVENTS-1:0] EVENTS_NONE = 6'h00;

    typedef enum logic [2:0] {
        SPD_NONE = 3'h0,
        SPD_10_HALF = 3'h1,
        SPD_10_FULL = 3'h2,
        SPD_100TX_HALF = 3'h3,
        SPD_100T4 = 3'h4,
        SPD_100TX_FULL = 3'h5,
        SPD_1000_HALF = 3'h6,
        SPD_1000_FULL = 3'h7
    } speed_duplex_type;

    // one-cycle pulses from the negotiation state machine
    typedef struct packed {
        logic enter_good_check;
        logic enter_ack_detect;
        logic enter_ability_detect;
        logic enter_next_page_wait;
        logic parallel_fault;
        logic page_received;
    } an_events_type;

    // levels from the negotiation and link logic
    typedef struct packed {
        logic an_enable;
        logic an_complete;
        speed_duplex_type best_common_ability;
        speed_duplex_type forced_speed;
        logic remote_fault;
        logic lp_an_able;
        logic lp_np_able;
        logic link_pass;
        logic pause_rx;
        logic pause_tx;
    } an_levels_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;
endpackage : an_status_pkg

// *** phy_autoneg_status_summary.sv ***
// status summary register of one copper port, with sticky event flags and an interrupt
//
// The plain strobed port was chosen for this implementation.
module phy_autoneg_status_summary (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire an_status_pkg::reg_req_type req_in,
    input wire an_status_pkg::an_events_type events_in,
    input wire an_status_pkg::an_levels_type levels_in,
    output logic [an_status_pkg::DATA_W-1:0] rdata_out,
    output logic irq_out
);
    import an_status_pkg::*;

    // level fields of the summary, one register each
    logic done_reg;
    speed_duplex_type speed_reg;
    logic remote_fault_reg;
    logic lp_an_able_reg;
    logic lp_np_able_reg;
    logic link_up_reg;
    logic pause_rx_reg;
    logic pause_tx_reg;

    // sticky flags of the summary, cleared by a read of it
    logic good_check_flag_reg;
    logic ack_detect_flag_reg;
    logic abil_detect_flag_reg;
    logic np_wait_flag_reg;
    logic pd_fault_flag_reg;
    logic page_rx_flag_reg;

    // interrupt flags, one per event, cleared by writing a one
    logic irq_good_check_reg;
    logic irq_ack_detect_reg;
    logic irq_abil_detect_reg;
    logic irq_np_wait_reg;
    logic irq_pd_fault_reg;
    logic irq_page_rx_reg;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_status_next;
    logic [NUM_EVENTS-1:0] irq_mask_reg;

    // decode and read path
    logic [NUM_EVENTS-1:0] ev_vec;
    logic [DATA_W-1:0] summary;
    logic [DATA_W-1:0] rdata_next;
    logic rd_status;
    logic rd_irq;
    logic rd_mask;
    logic wr_irq_status;
    logic wr_irq_mask;
    speed_duplex_type speed_sel;

    // true when the request hits a given offset with the given strobe
    function automatic logic hit(input reg_req_type r, input logic [ADDR_W-1:0] off, input logic strobe);
        hit = strobe && (r.addr == off);
    endfunction : hit

    // widen an event vector to the low bits of a bus word
    function automatic logic [DATA_W-1:0] widen(input logic [NUM_EVENTS-1:0] v);
        widen = {{(DATA_W-NUM_EVENTS){1'b0}}, v};
    endfunction : widen

    // next value of one sticky bit; the set beats the clear so no event is lost
    function automatic logic latch_event(input logic held, input logic pulse, input logic clear);
        latch_event = pulse || (held && !clear);
    endfunction : latch_event

    // strobe decode; a write to the summary is not decoded at all, so it cannot touch it
    assign rd_status = hit(req_in, STATUS_OFFSET, req_in.rd);
    assign rd_irq = hit(req_in, IRQ_STATUS_OFFSET, req_in.rd);
    assign rd_mask = hit(req_in, IRQ_MASK_OFFSET, req_in.rd);
    assign wr_irq_status = hit(req_in, IRQ_STATUS_OFFSET, req_in.wr);
    assign wr_irq_mask = hit(req_in, IRQ_MASK_OFFSET, req_in.wr);

    // gather the event pulses into one vector
    always_comb begin
        ev_vec = EVENTS_NONE;
        ev_vec[EV_GOOD_CHECK] = events_in.enter_good_check;
        ev_vec[EV_ACK_DETECT] = events_in.enter_ack_detect;
        ev_vec[EV_ABIL_DETECT] = events_in.enter_ability_detect;
        ev_vec[EV_NP_WAIT] = events_in.enter_next_page_wait;
        ev_vec[EV_PD_FAULT] = events_in.parallel_fault;
        ev_vec[EV_PAGE_RX] = events_in.page_received;
    end

    // forced mode is reported as is; negotiated result is gated by completion
    always_comb begin
        if (levels_in.an_enable) begin
            if (levels_in.an_complete) begin
                speed_sel = levels_in.best_common_ability;
            end else begin
                speed_sel = SPD_NONE;
            end
        end else begin
            speed_sel = levels_in.forced_speed;
        end
    end

    // completion bit, registered so the word is stable for a read; ignores the enable
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_reg <= RESET_VALUE[BIT_AN_DONE];
        end else begin
            done_reg <= levels_in.an_complete;
        end
    end

    // speed and duplex code after the enable and completion gating
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            speed_reg <= SPD_NONE;
        end else begin
            speed_reg <= speed_sel;
        end
    end

    // partner remote fault, a plain level with no latching
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            remote_fault_reg <= RESET_VALUE[BIT_REM_FAULT];
        end else begin
            remote_fault_reg <= levels_in.remote_fault;
        end
    end

    // partner negotiation ability
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lp_an_able_reg <= RESET_VALUE[BIT_LP_AN_ABLE];
        end else begin
            lp_an_able_reg <= levels_in.lp_an_able;
        end
    end

    // partner next page ability
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lp_np_able_reg <= RESET_VALUE[BIT_LP_NP_ABLE];
        end else begin
            lp_np_able_reg <= levels_in.lp_np_able;
        end
    end

    // link pass or fail state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_up_reg <= RESET_VALUE[BIT_LINK_UP];
        end else begin
            link_up_reg <= levels_in.link_pass;
        end
    end

    // receive pause resolution
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pause_rx_reg <= RESET_VALUE[BIT_PAUSE_RX];
        end else begin
            pause_rx_reg <= levels_in.pause_rx;
        end
    end

    // transmit pause resolution
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pause_tx_reg <= RESET_VALUE[BIT_PAUSE_TX];
        end else begin
            pause_tx_reg <= levels_in.pause_tx;
        end
    end

    // good-check entry flag; a read clears it, but an event in that same cycle survives
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            good_check_flag_reg <= RESET_VALUE[BIT_GOOD_CHECK];
        end else begin
            good_check_flag_reg <= latch_event(good_check_flag_reg, ev_vec[EV_GOOD_CHECK], rd_status);
        end
    end

    // acknowledge-detect entry flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_detect_flag_reg <= RESET_VALUE[BIT_ACK_DETECT];
        end else begin
            ack_detect_flag_reg <= latch_event(ack_detect_flag_reg, ev_vec[EV_ACK_DETECT], rd_status);
        end
    end

    // ability-detect entry flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            abil_detect_flag_reg <= RESET_VALUE[BIT_ABIL_DETECT];
        end else begin
            abil_detect_flag_reg <= latch_event(abil_detect_flag_reg, ev_vec[EV_ABIL_DETECT], rd_status);
        end
    end

    // next-page-wait entry flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            np_wait_flag_reg <= RESET_VALUE[BIT_NP_WAIT];
        end else begin
            np_wait_flag_reg <= latch_event(np_wait_flag_reg, ev_vec[EV_NP_WAIT], rd_status);
        end
    end

    // parallel detection fault flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pd_fault_flag_reg <= RESET_VALUE[BIT_PD_FAULT];
        end else begin
            pd_fault_flag_reg <= latch_event(pd_fault_flag_reg, ev_vec[EV_PD_FAULT], rd_status);
        end
    end

    // page received flag; writes never reach it, so software cannot fake or lose a page
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            page_rx_flag_reg <= RESET_VALUE[BIT_PAGE_RX];
        end else begin
            page_rx_flag_reg <= latch_event(page_rx_flag_reg, ev_vec[EV_PAGE_RX], rd_status);
        end
    end

    // assemble the summary word from live levels and sticky flags
    always_comb begin
        summary = RESET_VALUE;
        summary[BIT_AN_DONE] = done_reg;
        summary[SPEED_HI:SPEED_LO] = speed_reg;
        summary[BIT_REM_FAULT] = remote_fault_reg;
        summary[BIT_LP_AN_ABLE] = lp_an_able_reg;
        summary[BIT_LP_NP_ABLE] = lp_np_able_reg;
        summary[BIT_LINK_UP] = link_up_reg;
        summary[BIT_PAUSE_RX] = pause_rx_reg;
        summary[BIT_PAUSE_TX] = pause_tx_reg;
        summary[BIT_GOOD_CHECK] = good_check_flag_reg;
        summary[BIT_ACK_DETECT] = ack_detect_flag_reg;
        summary[BIT_ABIL_DETECT] = abil_detect_flag_reg;
        summary[BIT_NP_WAIT] = np_wait_flag_reg;
        summary[BIT_PD_FAULT] = pd_fault_flag_reg;
        summary[BIT_PAGE_RX] = page_rx_flag_reg;
    end

    // interrupt status is separate from the summary flags: write one to clear, set wins
    always_comb begin
        irq_status_next = EVENTS_NONE;
        for (int i = 0; i < NUM_EVENTS; i++) begin
            irq_status_next[i] = latch_event(irq_status[i], ev_vec[i], wr_irq_status && req_in.wdata[i]);
        end
    end

    // good-check interrupt flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_good_check_reg <= EVENTS_NONE[EV_GOOD_CHECK];
        end else begin
            irq_good_check_reg <= irq_status_next[EV_GOOD_CHECK];
        end
    end

    // acknowledge-detect interrupt flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_ack_detect_reg <= EVENTS_NONE[EV_ACK_DETECT];
        end else begin
            irq_ack_detect_reg <= irq_status_next[EV_ACK_DETECT];
        end
    end

    // ability-detect interrupt flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_abil_detect_reg <= EVENTS_NONE[EV_ABIL_DETECT];
        end else begin
            irq_abil_detect_reg <= irq_status_next[EV_ABIL_DETECT];
        end
    end

    // next-page-wait interrupt flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_np_wait_reg <= EVENTS_NONE[EV_NP_WAIT];
        end else begin
            irq_np_wait_reg <= irq_status_next[EV_NP_WAIT];
        end
    end

    // parallel fault interrupt flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_pd_fault_reg <= EVENTS_NONE[EV_PD_FAULT];
        end else begin
            irq_pd_fault_reg <= irq_status_next[EV_PD_FAULT];
        end
    end

    // page received interrupt flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_page_rx_reg <= EVENTS_NONE[EV_PAGE_RX];
        end else begin
            irq_page_rx_reg <= irq_status_next[EV_PAGE_RX];
        end
    end

    // interrupt flags back into one vector for the read path and the set/clear logic
    always_comb begin
        irq_status = EVENTS_NONE;
        irq_status[EV_GOOD_CHECK] = irq_good_check_reg;
        irq_status[EV_ACK_DETECT] = irq_ack_detect_reg;
        irq_status[EV_ABIL_DETECT] = irq_abil_detect_reg;
        irq_status[EV_NP_WAIT] = irq_np_wait_reg;
        irq_status[EV_PD_FAULT] = irq_pd_fault_reg;
        irq_status[EV_PAGE_RX] = irq_page_rx_reg;
    end

    // mask bit high enables that event onto the interrupt line
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_mask_reg <= EVENTS_NONE;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= req_in.wdata[NUM_EVENTS-1:0];
        end
    end

    // level interrupt from a flip-flop fed by the next status, so it changes on the same edge as the status bits
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_status_next & irq_mask_reg);
        end
    end

    // read mux; unmapped addresses and idle cycles read zero
    always_comb begin
        rdata_next = RESET_VALUE;
        if (rd_status) begin
            rdata_next = summary;
        end else if (rd_irq) begin
            rdata_next = widen(irq_status);
        end else if (rd_mask) begin
            rdata_next = widen(irq_mask_reg);
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= RESET_VALUE;
        end else begin
            rdata_out <= rdata_next;
        end
    end
endmodule : phy_autoneg_status_summary

// *** an_status_sva.sv ***
// checker: port-level properties of the negotiation status summary
module an_status_sva import an_status_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire reg_req_type req_in,
    input wire an_events_type events_in,
    input wire an_levels_type levels_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // summary read strobe, decoded once
    wire rd_sum = req_in.rd && req_in.addr == STATUS_OFFSET;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    rdata_idle_a: assert property (!$past(req_in.rd) |-> rdata_out == 16'h0000)
        else $error("read data not idle");
    done_bit_a: assert property (rd_sum && $past(rst_n_in) && $stable(levels_in.an_complete)
        |=> rdata_out[15] == $past(levels_in.an_complete)) else $error("done bit wrong");
    sticky_set_a: assert property (events_in.enter_good_check ##1 !rd_sum ##1 rd_sum |=> rdata_out[14])
        else $error("good check flag lost");
    sticky_clear_a: assert property (rd_sum && !events_in.parallel_fault ##1 !events_in.parallel_fault
        ##1 rd_sum |=> !rdata_out[7]) else $error("fault flag not cleared by read");
    speed_code_a: assert property (rd_sum && $past(rst_n_in) && $stable(levels_in) |=> rdata_out[10:8] ==
        (!$past(levels_in.an_enable) ? $past(levels_in.forced_speed) : $past(levels_in.an_complete) ?
        $past(levels_in.best_common_ability) : 3'h0)) else $error("speed field wrong");
    level_bits_a: assert property (rd_sum && $past(rst_n_in) && $stable(levels_in)
        |=> {rdata_out[6], rdata_out[4:0]} == $past(levels_in[5:0])) else $error("level bits wrong");
    // only a write can drop the interrupt; mask writes land one edge late
    irq_hold_a: assert property (irq_out && !req_in.wr && !$past(req_in.wr) |=> irq_out)
        else $error("interrupt dropped without a write");
    irq_rise_a: assert property ($rose(irq_out) |-> $past(events_in) != '0 || $past(req_in.wr)
        || $past(req_in.wr, 2)) else $error("interrupt rose without cause");
    cover property (rd_sum ##1 rdata_out[14]);
    cover property ($rose(irq_out));
    cover property (req_in.wr && req_in.addr == STATUS_OFFSET);
endmodule : an_status_sva

bind phy_autoneg_status_summary an_status_sva an_status_sva_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .req_in(req_in), .events_in(events_in), .levels_in(levels_in), .rdata_out(rdata_out), .irq_out(irq_out));

// *** an_source.sv ***
// partner: negotiation and link source feeding the status summary
module an_source import an_status_pkg::*; (
    input wire logic clk_in,
    output an_events_type events_out,
    output an_levels_type levels_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        events_out = '0;
        levels_out = '0;
    end
    // one-cycle entry or fault pulse, launched just after an edge
    task automatic pulse(input an_events_type ev);
        @(posedge clk_in);
        events_out <= ev;
        @(posedge clk_in);
        events_out <= '0;
    endtask : pulse
    // levels settle for a full cycle before anyone reads them
    task automatic set_levels(input an_levels_type lv);
        @(posedge clk_in);
        levels_out <= lv;
        @(posedge clk_in);
    endtask : set_levels
endmodule : an_source

// *** tb.sv ***
// testbench: register reads and writes against the negotiation status summary
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import an_status_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    reg_req_type req_in = '0;
    an_events_type events_in;
    an_levels_type levels_in;
    logic [DATA_W-1:0] rdata_out;
    logic irq_out;
    int num_errors = 0;
    int tests_run = 0;
    int sb[6] = '{5, 7, 11, 12, 13, 14}; // summary bit of each event line
    phy_autoneg_status_summary phy_autoneg_status_summary_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .req_in(req_in), .events_in(events_in), .levels_in(levels_in), .rdata_out(rdata_out), .irq_out(irq_out));
    an_source an_source_inst (.clk_in(clk_in), .events_out(events_in), .levels_out(levels_in));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req_in.wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req_in.rd <= 1'b0;
        #1 chk(rdata_out, exp);
    endtask : rdc
    task automatic results;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        an_levels_type lv;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rdc(STATUS_OFFSET, RESET_VALUE);
        wr(IRQ_MASK_OFFSET, 16'h003F);
        for (int i = 0; i < 6; i++) begin
            an_source_inst.pulse(6'(1 << i));
            rdc(STATUS_OFFSET, 16'h0001 << sb[i]);
            rdc(STATUS_OFFSET, 16'h0000);
        end
        // an event in the very cycle of a read must survive that read
        fork
            an_source_inst.pulse(6'h20);
            rdc(STATUS_OFFSET, 16'h0000);
        join
        rdc(STATUS_OFFSET, 16'h4000);
        rdc(IRQ_STATUS_OFFSET, 16'h003F);
        chk(16'(irq_out), 16'h0001);
        wr(IRQ_STATUS_OFFSET, 16'h003F);
        #1 chk(16'(irq_out), 16'h0000);
        wr(IRQ_MASK_OFFSET, 16'h0000);
        an_source_inst.pulse(6'h01);
        rdc(IRQ_STATUS_OFFSET, 16'h0020);
        chk(16'(irq_out), 16'h0000);
        wr(IRQ_MASK_OFFSET, 16'h0020);
        @(posedge clk_in);
        #1 chk(16'(irq_out), 16'h0001);
        // a write must neither clear a pending flag nor plant a value
        an_source_inst.pulse(6'h02);
        wr(STATUS_OFFSET, 16'hFFFF);
        rdc(STATUS_OFFSET, 16'h00A0);
        rdc(8'h55, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            lv = '0;
            lv.an_enable = 1'b1;
            lv.an_complete = 1'b1;
            lv.best_common_ability = speed_duplex_type'(c);
            lv.forced_speed = speed_duplex_type'(7 - c);
            an_source_inst.set_levels(lv);
            rdc(STATUS_OFFSET, {1'h1, 4'h0, 3'(c), 8'h00});
            lv.an_complete = 1'b0;
            an_source_inst.set_levels(lv);
            rdc(STATUS_OFFSET, 16'h0000);
            lv.an_enable = 1'b0;
            an_source_inst.set_levels(lv);
            rdc(STATUS_OFFSET, {5'h00, 3'(7 - c), 8'h00});
        end
        an_source_inst.set_levels(14'h002A);
        rdc(STATUS_OFFSET, 16'h004A);
        an_source_inst.set_levels(14'h0015);
        rdc(STATUS_OFFSET, 16'h0015);
        results();
    end
    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        results();
    end
endmodule : tb
